//--- hdl/branch_pkg.sv
// shared constants and types for the conditional branch unit
package branch_pkg;

  // ----------------------------------------------------------------
  // instruction format
  // ----------------------------------------------------------------
  localparam int INSTR_W = 24;
  localparam int PC_W = 24;
  localparam int OPC_HI = 23;
  localparam int OPC_LO = 16;
  localparam int OFFSET_W = 16;
  localparam logic [7:0] OPC_SIGNED_AT_MOST = 8'h34;
  localparam logic [7:0] OPC_UNSIGNED_AT_MOST = 8'h36;
  localparam logic [7:0] OPC_SIGNED_BELOW = 8'h35;
  localparam logic [7:0] OPC_UNSIGNED_BELOW = 8'h39;
  localparam logic [7:0] OPC_RESULT_MINUS = 8'h33;
  localparam logic [PC_W-1:0] PC_STEP = 24'h000002;

  // ----------------------------------------------------------------
  // timing, in core clock cycles
  // ----------------------------------------------------------------
  localparam int NOT_TAKEN_CYCLES = 1;
  localparam int TAKEN_CYCLES_SHORT = 2;
  localparam int TAKEN_CYCLES_DEEP = 4;
  localparam int FLUSH_CNT_W = 3;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h004;
  localparam logic [ADDR_W-1:0] TAKEN_COUNT_OFFSET = 12'h008;
  localparam logic [ADDR_W-1:0] LAST_TARGET_OFFSET = 12'h00c;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_OP_LO = 1;
  localparam int STATUS_OP_HI = 3;
  localparam int STATUS_TAKEN_BIT = 4;
  localparam int STATUS_DEEP_BIT = 5;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  // unsigned-below and not-carry share one code: they are one operation
  typedef enum logic [2:0] {
    op_none = 3'b000,
    op_signed_at_most = 3'b001,
    op_unsigned_at_most = 3'b010,
    op_signed_below = 3'b011,
    op_unsigned_below = 3'b100,
    op_result_minus = 3'b101
  } branch_op_t;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_flush = 2'b01
  } seq_state_t;

  typedef struct packed {
    logic result_msb;
    logic signed_wrap;
    logic all_clear;
    logic borrow_inverse;
  } status_flags_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage

//--- hdl/conditional_branch_unit.sv
// conditional pc-relative branch decode and execute with apb status registers
`timescale 1ns/1ns

module conditional_branch_unit #(
  parameter bit DEEP_PIPE = 1'b0
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // apb slave
  input wire branch_pkg::apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // issue from decode
  input wire logic instr_valid,
  input wire logic [branch_pkg::INSTR_W-1:0] instr,
  input wire logic [branch_pkg::PC_W-1:0] instr_pc,
  input wire branch_pkg::status_flags_t flags,
  // result to fetch and pc
  output logic issue_ready,
  output logic retire_valid,
  output logic is_branch,
  output logic branch_taken,
  output logic pc_load,
  output logic [branch_pkg::PC_W-1:0] pc_next,
  output logic slot_nop,
  output logic flags_write
);

  localparam int TAKEN_CYCLES =
    DEEP_PIPE ? branch_pkg::TAKEN_CYCLES_DEEP : branch_pkg::TAKEN_CYCLES_SHORT;
  localparam logic [branch_pkg::FLUSH_CNT_W-1:0] FLUSH_LOAD =
    branch_pkg::FLUSH_CNT_W'(TAKEN_CYCLES - 2);

  // ----------------------------------------------------------------
  // decode and condition
  // ----------------------------------------------------------------
  branch_pkg::branch_op_t op;
  logic cond;
  logic [branch_pkg::PC_W-1:0] seq_pc;
  logic [branch_pkg::PC_W-1:0] byte_offset;
  logic [branch_pkg::PC_W-1:0] target;
  logic enable_q;
  logic [7:0] opc;

  assign opc = instr[branch_pkg::OPC_HI:branch_pkg::OPC_LO];

  always_comb begin
    op = branch_pkg::op_none;
    if (enable_q) begin
      case (opc)
        branch_pkg::OPC_SIGNED_AT_MOST: op = branch_pkg::op_signed_at_most;
        branch_pkg::OPC_UNSIGNED_AT_MOST: op = branch_pkg::op_unsigned_at_most;
        branch_pkg::OPC_SIGNED_BELOW: op = branch_pkg::op_signed_below;
        // one code covers both mnemonics
        branch_pkg::OPC_UNSIGNED_BELOW: op = branch_pkg::op_unsigned_below;
        branch_pkg::OPC_RESULT_MINUS: op = branch_pkg::op_result_minus;
        default: op = branch_pkg::op_none;
      endcase
    end
  end

  always_comb begin
    case (op)
      branch_pkg::op_signed_at_most:
        cond = flags.all_clear | (flags.result_msb ^ flags.signed_wrap);
      branch_pkg::op_unsigned_at_most:
        cond = ~flags.borrow_inverse | flags.all_clear;
      branch_pkg::op_signed_below:
        cond = flags.result_msb ^ flags.signed_wrap;
      branch_pkg::op_unsigned_below:
        cond = ~flags.borrow_inverse;
      branch_pkg::op_result_minus:
        cond = flags.result_msb;
      default:
        cond = 1'b0;
    endcase
  end

  // sign-extend the word count and scale it to bytes
  assign byte_offset = {{(branch_pkg::PC_W - branch_pkg::OFFSET_W - 1){instr[15]}},
                        instr[branch_pkg::OFFSET_W-1:0], 1'b0};
  assign seq_pc = instr_pc + branch_pkg::PC_STEP;
  assign target = seq_pc + byte_offset;

  // ----------------------------------------------------------------
  // execute sequencer
  // ----------------------------------------------------------------
  branch_pkg::seq_state_t state_q, state_d;
  logic [branch_pkg::FLUSH_CNT_W-1:0] flush_cnt_q, flush_cnt_d;
  logic issue_ready_q, issue_ready_d;
  logic retire_valid_q, retire_valid_d;
  logic is_branch_q, is_branch_d;
  logic taken_q, taken_d;
  logic pc_load_q, pc_load_d;
  logic [branch_pkg::PC_W-1:0] pc_next_q, pc_next_d;
  logic slot_nop_q, slot_nop_d;
  branch_pkg::branch_op_t last_op_q, last_op_d;
  logic [branch_pkg::PC_W-1:0] last_target_q, last_target_d;
  logic accept;
  logic take;

  assign accept = instr_valid & issue_ready_q;
  assign take = accept & cond;

  always_comb begin
    state_d = state_q;
    flush_cnt_d = flush_cnt_q;
    issue_ready_d = issue_ready_q;
    retire_valid_d = 1'b0;
    is_branch_d = is_branch_q;
    taken_d = taken_q;
    pc_load_d = 1'b0;
    pc_next_d = pc_next_q;
    slot_nop_d = slot_nop_q;
    last_op_d = last_op_q;
    last_target_d = last_target_q;
    case (state_q)
      branch_pkg::st_idle: begin
        if (accept) begin
          retire_valid_d = 1'b1;
          is_branch_d = (op != branch_pkg::op_none);
          taken_d = cond;
          if (op != branch_pkg::op_none) begin
            last_op_d = op;
          end
          if (cond) begin
            pc_load_d = 1'b1;
            pc_next_d = target;
            last_target_d = target;
            slot_nop_d = 1'b1;
            issue_ready_d = 1'b0;
            flush_cnt_d = FLUSH_LOAD;
            state_d = branch_pkg::st_flush;
          end else begin
            // fall through in a single cycle, ready stays high
            pc_next_d = seq_pc;
          end
        end
      end
      branch_pkg::st_flush: begin
        // the fetched slot behind the branch is held as a nop
        if (flush_cnt_q == '0) begin
          slot_nop_d = 1'b0;
          issue_ready_d = 1'b1;
          state_d = branch_pkg::st_idle;
        end else begin
          flush_cnt_d = flush_cnt_q - 1'b1;
        end
      end
      default: begin
        state_d = branch_pkg::st_idle;
        issue_ready_d = 1'b1;
        slot_nop_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= branch_pkg::st_idle;
      flush_cnt_q <= '0;
      issue_ready_q <= 1'b1;
      retire_valid_q <= 1'b0;
      is_branch_q <= 1'b0;
      taken_q <= 1'b0;
      pc_load_q <= 1'b0;
      pc_next_q <= '0;
      slot_nop_q <= 1'b0;
      last_op_q <= branch_pkg::op_none;
      last_target_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
      flush_cnt_q <= flush_cnt_d;
      issue_ready_q <= issue_ready_d;
      retire_valid_q <= retire_valid_d;
      is_branch_q <= is_branch_d;
      taken_q <= taken_d;
      pc_load_q <= pc_load_d;
      pc_next_q <= pc_next_d;
      slot_nop_q <= slot_nop_d;
      last_op_q <= last_op_d;
      last_target_q <= last_target_d;
    end
  end

  // ----------------------------------------------------------------
  // apb register file
  // ----------------------------------------------------------------
  // one wait state so read data can come straight from a flip-flop
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic enable_d;
  logic [31:0] taken_count_q, taken_count_d;
  logic access;
  logic commit;
  logic mapped;
  logic count_clear;

  assign access = apb_req.psel & apb_req.penable;
  assign commit = access & pready_q;
  assign mapped = (apb_req.paddr == branch_pkg::CTRL_OFFSET) |
                  (apb_req.paddr == branch_pkg::STATUS_OFFSET) |
                  (apb_req.paddr == branch_pkg::TAKEN_COUNT_OFFSET) |
                  (apb_req.paddr == branch_pkg::LAST_TARGET_OFFSET);
  assign count_clear = commit & apb_req.pwrite &
                       (apb_req.paddr == branch_pkg::TAKEN_COUNT_OFFSET);

  always_comb begin
    pready_d = access & ~pready_q;
    pslverr_d = 1'b0;
    prdata_d = '0;
    enable_d = enable_q;
    taken_count_d = taken_count_q;
    if (access & ~pready_q) begin
      pslverr_d = ~mapped;
      if (~apb_req.pwrite) begin
        case (apb_req.paddr)
          branch_pkg::CTRL_OFFSET:
            prdata_d[branch_pkg::CTRL_ENABLE_BIT] = enable_q;
          branch_pkg::STATUS_OFFSET: begin
            prdata_d[branch_pkg::STATUS_BUSY_BIT] = ~issue_ready_q;
            prdata_d[branch_pkg::STATUS_OP_HI:branch_pkg::STATUS_OP_LO] = last_op_q;
            prdata_d[branch_pkg::STATUS_TAKEN_BIT] = taken_q;
            prdata_d[branch_pkg::STATUS_DEEP_BIT] = DEEP_PIPE;
          end
          branch_pkg::TAKEN_COUNT_OFFSET:
            prdata_d = taken_count_q;
          branch_pkg::LAST_TARGET_OFFSET:
            prdata_d[branch_pkg::PC_W-1:0] = last_target_q;
          default:
            prdata_d = '0;
        endcase
      end
    end
    if (commit & apb_req.pwrite & (apb_req.paddr == branch_pkg::CTRL_OFFSET)) begin
      enable_d = apb_req.pwdata[branch_pkg::CTRL_ENABLE_BIT];
    end
    // a branch taken in the clearing cycle still counts
    if (count_clear) begin
      taken_count_d = {31'h0, take};
    end else if (take) begin
      taken_count_d = taken_count_q + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      enable_q <= branch_pkg::CTRL_ENABLE_RESET;
      taken_count_q <= '0;
    end else if (ce) begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      enable_q <= enable_d;
      taken_count_q <= taken_count_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic flags_write_q;

  // this unit never owns a status write
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_write_q <= 1'b0;
    end else if (ce) begin
      flags_write_q <= 1'b0;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign issue_ready = issue_ready_q;
  assign retire_valid = retire_valid_q;
  assign is_branch = is_branch_q;
  assign branch_taken = taken_q;
  assign pc_load = pc_load_q;
  assign pc_next = pc_next_q;
  assign slot_nop = slot_nop_q;
  assign flags_write = flags_write_q;

endmodule // conditional_branch_unit

//--- tb/branch_chk.sv
// concurrent checks on the branch unit ports
`timescale 1ns/1ns
module branch_chk #(
  parameter bit DEEP_PIPE = 1'b0
) (
  // core
  input logic clk,
  input logic rst,
  input logic ce,
  // apb
  input branch_pkg::apb_req_t apb_req,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  // issue and result
  input logic instr_valid,
  input logic [23:0] instr,
  input logic [23:0] instr_pc,
  input branch_pkg::status_flags_t flags,
  input logic issue_ready,
  input logic retire_valid,
  input logic is_branch,
  input logic branch_taken,
  input logic pc_load,
  input logic [23:0] pc_next,
  input logic slot_nop,
  input logic flags_write
);
  localparam int TL = DEEP_PIPE ? 3 : 1;
  logic acc;
  logic cond;
  logic exp_q;
  logic [23:0] pc2_q;
  logic [23:0] off_q;
  assign acc = ce & instr_valid & issue_ready;
  always_comb begin
    case (instr[23:16])
      branch_pkg::OPC_SIGNED_AT_MOST: cond = flags.all_clear | (flags.result_msb ^ flags.signed_wrap);
      branch_pkg::OPC_UNSIGNED_AT_MOST: cond = ~flags.borrow_inverse | flags.all_clear;
      branch_pkg::OPC_SIGNED_BELOW: cond = flags.result_msb ^ flags.signed_wrap;
      branch_pkg::OPC_UNSIGNED_BELOW: cond = ~flags.borrow_inverse;
      branch_pkg::OPC_RESULT_MINUS: cond = flags.result_msb;
      default: cond = 1'b0;
    endcase
  end
  // expectations latched at acceptance, since inputs move on afterwards
  always_ff @(posedge clk) begin
    if (acc) begin
      exp_q <= cond;
      pc2_q <= instr_pc + branch_pkg::PC_STEP;
      off_q <= {{7{instr[15]}}, instr[15:0], 1'b0};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  retire_a: assert property (acc |=> retire_valid) else $error("no retire after accept");
  single_a: assert property (ce && !acc |=> !retire_valid) else $error("stray retire");
  cond_a: assert property (retire_valid && is_branch |-> branch_taken == exp_q)
    else $error("wrong branch decision");
  target_a: assert property (pc_load |-> pc_next == pc2_q + off_q)
    else $error("wrong branch target");
  fall_a: assert property (retire_valid && !branch_taken |-> pc_next == pc2_q && !pc_load)
    else $error("wrong fall through");
  load_nop_a: assert property (retire_valid |-> pc_load == branch_taken && slot_nop == branch_taken)
    else $error("slot not flushed");
  flush_len_a: assert property (pc_load |-> !issue_ready ##TL issue_ready && !slot_nop)
    else $error("wrong taken length");
  no_flag_a: assert property (!flags_write) else $error("status flags written");
  apb_wait_a: assert property (apb_req.psel && apb_req.penable && !pready |=> pready)
    else $error("apb answer late");
  cover property (pc_load);
  cover property (retire_valid && is_branch && !branch_taken);
  cover property (pready && pslverr);
endmodule // branch_chk

//--- tb/tb.sv
// self-checking bench for the conditional branch unit
`timescale 1ns/1ns
module tb;
  localparam bit DEEP = 1'b1;
  localparam int TC = branch_pkg::TAKEN_CYCLES_DEEP;
  logic clk, rst, ce, instr_valid;
  logic [23:0] instr, instr_pc, pc_next, last_tgt;
  branch_pkg::apb_req_t apb_req;
  branch_pkg::status_flags_t flags;
  logic [31:0] prdata;
  logic pready, pslverr, issue_ready, retire_valid, is_branch, branch_taken, pc_load, slot_nop;
  logic flags_write, prev_tk;
  int n_errors, checks_done, n_tk;
  // rows: opcode, flags msb wrap zero borrow, {br, taken}
  logic [15:0] rows [16] = '{16'h3423, 16'h3483, 16'h34c2, 16'h3402, 16'h3603, 16'h3612,
    16'h3633, 16'h3583, 16'h3543, 16'h35c2, 16'h3522, 16'h3903, 16'h3912, 16'h3383,
    16'h3372, 16'h3d00};
  conditional_branch_unit #(.DEEP_PIPE(DEEP)) DUT (.clk(clk), .rst(rst), .ce(ce),
    .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_valid(instr_valid), .instr(instr), .instr_pc(instr_pc), .flags(flags),
    .issue_ready(issue_ready), .retire_valid(retire_valid), .is_branch(is_branch),
    .branch_taken(branch_taken), .pc_load(pc_load), .pc_next(pc_next),
    .slot_nop(slot_nop), .flags_write(flags_write));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] ex);
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    // hold the access until pready is seen high at a rising edge; watchdog ends a hang
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    chk({pready, pslverr, prdata}, {1'b1, ex});
    apb_req <= '0;
    prev_tk = 1'b0;
  endtask
  task automatic issue(input logic [23:0] w, input logic [23:0] pc, input logic [3:0] f,
                       input logic [1:0] ex);
    int n;
    logic [23:0] tgt;
    n = 0;
    tgt = pc + 24'h000002 + {{7{w[15]}}, w[15:0], 1'b0};
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= w;
    instr_pc <= pc;
    flags <= branch_pkg::status_flags_t'(f);
    forever begin
      @(negedge clk);
      if (issue_ready === 1'b1 || n == 8) break;
      n++;
    end
    chk(n, prev_tk ? TC - 2 : 0);
    @(posedge clk);
    instr_valid <= 1'b0;
    @(negedge clk);
    chk({retire_valid, is_branch, branch_taken, pc_load, slot_nop}, {1'b1, ex, ex[0], ex[0]});
    chk(pc_next, ex[0] ? tgt : pc + 24'h000002);
    if (ex[0]) last_tgt = tgt;
    prev_tk = ex[0];
  endtask
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    apb_req = '0;
    instr_valid = 1'b0;
    instr = 24'h0;
    instr_pc = 24'h0;
    flags = '0;
    prev_tk = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({issue_ready, retire_valid, pc_load, slot_nop, flags_write, pc_next}, 29'h10000000);
    // an offer while ce is low must wait until ce returns
    @(posedge clk);
    ce <= 1'b0;
    instr_valid <= 1'b1;
    instr <= 24'h3d0000;
    repeat (3) @(posedge clk);
    chk({retire_valid, issue_ready}, 2'b01);
    ce <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    @(posedge clk);
    chk({retire_valid, is_branch, pc_next}, 26'h2000002);
    apb(1'b0, branch_pkg::CTRL_OFFSET, 32'h0, 33'h000000001);
    apb(1'b0, branch_pkg::STATUS_OFFSET, 32'h0, 33'h000000020);
    apb(1'b0, 12'h010, 32'h0, 33'h100000000);
    // extreme offsets alternate to hit both ends of the signed range
    for (int i = 0; i < 16; i++) begin
      issue({rows[i][15:8], i[0] ? 16'h8000 : 16'h7fff}, 24'h002000 + 24'(i * 8),
            rows[i][7:4], rows[i][1:0]);
      n_tk += int'(rows[i][0]);
    end
    apb(1'b0, branch_pkg::TAKEN_COUNT_OFFSET, 32'h0, {1'b0, 32'(n_tk)});
    apb(1'b0, branch_pkg::LAST_TARGET_OFFSET, 32'h0, {9'h000, last_tgt});
    apb(1'b1, branch_pkg::TAKEN_COUNT_OFFSET, 32'h1, 33'h000000000);
    apb(1'b0, branch_pkg::TAKEN_COUNT_OFFSET, 32'h0, 33'h000000000);
    apb(1'b1, branch_pkg::CTRL_OFFSET, 32'h0, 33'h000000000);
    issue(24'h330005, 24'h004000, 4'h8, 2'b00);
    apb(1'b1, branch_pkg::CTRL_OFFSET, 32'h1, 33'h000000000);
    issue(24'h33ffff, 24'hfffffe, 4'h8, 2'b11);
    issue(24'h330000, 24'h000010, 4'h8, 2'b11);
    // reset in mid-flush must drop the nop slot and reopen issue at once
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({issue_ready, slot_nop, pc_next}, 26'h2000000);
    print_verdict();
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
endmodule // tb
bind conditional_branch_unit branch_chk #(.DEEP_PIPE(DEEP_PIPE)) chk_i (.clk(clk), .rst(rst),
  .ce(ce), .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .instr_valid(instr_valid), .instr(instr), .instr_pc(instr_pc), .flags(flags),
  .issue_ready(issue_ready), .retire_valid(retire_valid), .is_branch(is_branch),
  .branch_taken(branch_taken), .pc_load(pc_load), .pc_next(pc_next), .slot_nop(slot_nop),
  .flags_write(flags_write));
